// ---- src/readout_pkg.sv ----
// Shared constants and carriers for the result readout port
package readout_pkg;

    localparam int RES_W = 10;
    localparam int UPPER_W = 8;
    localparam int LOWER_W = 2;
    localparam int UPPER_LSB = 2;
    localparam int LOWER_MSB = 1;
    localparam int CLK_MHZ = 50;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int LSB_SETTLE_NS = 500;
    localparam int SETTLE_CYC = (LSB_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_RESULT = 0;
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic [RES_W-1:0] code;
    } result_t;

    typedef struct packed {
        logic [UPPER_W-1:0] data;
        logic oe;
    } upper_bus_t;

    typedef struct packed {
        logic [LOWER_W-1:0] data;
        logic oe;
    } lower_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_SETTLE = 3'b100
    } conv_state_t;

endpackage

// ---- src/result_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module result_fifo
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        mem_d = mem_q;
        if (push)
        begin
            mem_d[wr_q] = in_data;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
endmodule

// ---- src/adc_result_readout_port.sv ----
// Readout port of a 10-bit converter: three-state result byte groups
`timescale 1ns/100ps
module adc_result_readout_port
    import readout_pkg::*;
#(
    parameter int SETTLE_CYCLES = readout_pkg::SETTLE_CYC,
    parameter int DEPTH = readout_pkg::FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Converter core side
    input wire logic start_pulse,
    input wire logic core_valid,
    output logic core_ready,
    input wire logic [readout_pkg::RES_W-1:0] core_code,
    // Stand-alone strap: pending drives both enables
    input wire logic standalone,
    // Host enables
    input wire logic upper_byte_enable_n,
    input wire logic lower_bits_enable_n,
    // Pins
    output logic conversion_pending_n,
    output readout_pkg::upper_bus_t result_upper_lines,
    output readout_pkg::lower_bus_t result_lower_lines
);
    import readout_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    // ----------------------------------------------------------------
    // Result buffering
    // ----------------------------------------------------------------
    logic fifo_valid, fifo_pop;
    logic [RES_W-1:0] fifo_data;

    // Back-pressure: a full FIFO stalls the core's result stream
    result_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(core_valid),
        .in_ready(core_ready),
        .in_data(core_code),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ----------------------------------------------------------------
    // Conversion sequencing
    // ----------------------------------------------------------------
    conv_state_t st_q, st_d;
    result_t res_q, res_d;
    logic start_q, start_d;
    logic pend_n_q, pend_n_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic settled_q, settled_d;
    logic start_rise, start_fall;

    always_comb
    begin
        start_d = start_pulse;
        start_rise = start_pulse && !start_q;
        start_fall = !start_pulse && start_q;
        st_d = st_q;
        res_d = res_q;
        pend_n_d = pend_n_q;
        cnt_d = cnt_q;
        settled_d = settled_q;
        fifo_pop = 1'b0;
        if (start_rise)
        begin
            // Previous result is discarded before a new one is taken
            res_d.code = RES_W'(RESET_RESULT);
            pend_n_d = 1'b1;
            settled_d = 1'b0;
            st_d = ST_IDLE;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    if (start_fall && pend_n_q)
                    begin
                        st_d = ST_BUSY;
                    end
                end
                ST_BUSY:
                begin
                    if (fifo_valid)
                    begin
                        fifo_pop = 1'b1;
                        res_d.code = fifo_data;
                        pend_n_d = 1'b0;
                        cnt_d = '0;
                        st_d = ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    // Low bit still rippling: hold stand-alone drivers off
                    if (cnt_q == CW'(SETTLE_CYCLES - 1))
                    begin
                        settled_d = 1'b1;
                        st_d = ST_IDLE;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= ST_IDLE;
            res_q <= '0;
            start_q <= 1'b0;
            pend_n_q <= 1'b0;
            cnt_q <= '0;
            settled_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            res_q <= res_d;
            start_q <= start_d;
            pend_n_q <= pend_n_d;
            cnt_q <= cnt_d;
            settled_q <= settled_d;
        end
    end

    // ----------------------------------------------------------------
    // Three-state output groups
    // ----------------------------------------------------------------
    upper_bus_t up_q, up_d;
    lower_bus_t lo_q, lo_d;
    logic en_up, en_lo;

    always_comb
    begin
        // Stand-alone ties both enables to pending, gated by settling
        en_up = standalone ? (!pend_n_d && settled_d)
                           : !upper_byte_enable_n;
        en_lo = standalone ? (!pend_n_d && settled_d)
                           : !lower_bits_enable_n;
        // Fixed left-justified split, no alignment option exists
        up_d.data = res_d.code[RES_W-1:UPPER_LSB];
        up_d.oe = en_up;
        // Lower group is independent; the host places it on bus bits 7..6
        lo_d.data = res_d.code[LOWER_MSB:0];
        lo_d.oe = en_lo;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            up_q <= '0;
            lo_q <= '0;
        end
        else
        begin
            up_q <= up_d;
            lo_q <= lo_d;
        end
    end

    // Only the two lower lines exist, so the other six low-byte bits
    // are whatever the bus floats to and nothing here reads them
    assign result_upper_lines = up_q;
    assign result_lower_lines = lo_q;
    assign conversion_pending_n = pend_n_q;
endmodule

// ---- dv/readout_monitor.sv ----
// Pin checker for the readout port
`timescale 1ns/100ps
module readout_monitor
    import readout_pkg::*;
#(
    parameter int SETTLE_CYCLES = 25
)
(
    // Clock, reset, controls
    input wire logic clk,
    input wire logic nrst,
    input wire logic start_pulse,
    input wire logic standalone,
    input wire logic upper_byte_enable_n,
    input wire logic lower_bits_enable_n,
    // Pins
    input wire logic conversion_pending_n,
    input wire readout_pkg::upper_bus_t result_upper_lines,
    input wire readout_pkg::lower_bus_t result_lower_lines
);
    // Cycles since pending fell; saturates so long idles stay harmless
    logic [7:0] wait_q;
    logic [7:0] wait_d;
    always_comb
        wait_d = conversion_pending_n ? 8'h00 :
            (wait_q == 8'hFF ? wait_q : wait_q + 8'h01);
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            wait_q <= 8'h00;
        else
            wait_q <= wait_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_rise;
        !start_pulse ##1 start_pulse;
    endsequence
    a_rise_pending: assert property (s_rise |=> conversion_pending_n)
        else $error("pending not raised");
    a_rise_clear: assert property (s_rise |=> result_upper_lines.data == 8'h00
        && result_lower_lines.data == 2'h0)
        else $error("result not cleared");
    a_upper_on: assert property (!standalone && !upper_byte_enable_n
        |=> result_upper_lines.oe)
        else $error("upper not driven");
    a_upper_off: assert property (!standalone && upper_byte_enable_n
        |=> !result_upper_lines.oe)
        else $error("upper driven");
    a_lower_on: assert property (!standalone && !lower_bits_enable_n
        |=> result_lower_lines.oe)
        else $error("lower not driven");
    a_lower_off: assert property (!standalone && lower_bits_enable_n
        |=> !result_lower_lines.oe)
        else $error("lower driven");
    a_standalone_hiz: assert property (standalone && conversion_pending_n
        |=> !result_upper_lines.oe && !result_lower_lines.oe)
        else $error("driven while converting");
    a_settle_delay: assert property (standalone && wait_q < 8'h40
        && $rose(result_upper_lines.oe) |-> wait_q == 8'(SETTLE_CYCLES))
        else $error("settle delay wrong");
    a_result_hold: assert property (!conversion_pending_n && !start_pulse
        |=> $stable(result_upper_lines.data)
        && $stable(result_lower_lines.data))
        else $error("result changed while idle");
endmodule
bind adc_result_readout_port readout_monitor #(
    .SETTLE_CYCLES(SETTLE_CYCLES)) mon_u (.clk, .nrst, .start_pulse,
    .standalone, .upper_byte_enable_n, .lower_bits_enable_n,
    .conversion_pending_n, .result_upper_lines, .result_lower_lines);

// ---- dv/host_reader.sv ----
// Host model: reads both groups as bytes of an 8-bit bus
`timescale 1ns/100ps
module host_reader
    import readout_pkg::*;
(
    // Pins
    input wire readout_pkg::upper_bus_t result_upper_lines,
    input wire readout_pkg::lower_bus_t result_lower_lines,
    // Rebuilt values
    output logic [7:0] low_byte,
    output logic [9:0] host_word
);
    logic [7:0] raw_up;
    logic [7:0] raw_low;
    // Released lines show a changed value, never the last one
    assign raw_up = result_upper_lines.oe ? result_upper_lines.data :
        ~result_upper_lines.data;
    // Bits 5:0 float on the bus, so they carry junk
    assign raw_low = {(result_lower_lines.oe ? result_lower_lines.data :
        ~result_lower_lines.data), 6'h2D};
    assign low_byte = raw_low & 8'hC0;
    assign host_word = 10'(4 * raw_up) + 10'(low_byte / 64);
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the readout port
`timescale 1ns/100ps
module tb_top;
    import readout_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start_pulse = 1'b0;
    logic core_valid = 1'b0;
    logic core_ready;
    logic [9:0] core_code = 10'h000;
    logic standalone = 1'b0;
    logic upper_byte_enable_n = 1'b1;
    logic lower_bits_enable_n = 1'b1;
    logic conversion_pending_n;
    upper_bus_t result_upper_lines;
    lower_bus_t result_lower_lines;
    logic [7:0] low_byte;
    logic [9:0] host_word;
    int miscompares = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    adc_result_readout_port #(.SETTLE_CYCLES(25), .DEPTH(32)) dut_u (.clk,
        .nrst, .start_pulse, .core_valid, .core_ready, .core_code,
        .standalone, .upper_byte_enable_n, .lower_bits_enable_n,
        .conversion_pending_n, .result_upper_lines, .result_lower_lines);
    host_reader host_u (.result_upper_lines, .result_lower_lines,
        .low_byte, .host_word);
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Fill the buffer until it refuses; nothing drains it while idle
    task automatic fill_fifo();
        int taken;
        taken = 0;
        core_valid = 1'b1;
        for (int i = 0; i < 40 && core_ready === 1'b1; i++)
        begin
            core_code = 10'(taken * 33);
            taken++;
            cycles(1);
        end
        check("words taken", 16'd32, 16'(taken));
        core_valid = 1'b0;
    endtask
    task automatic convert(input logic [9:0] code, input logic alone);
        int n;
        start_pulse = 1'b1;
        cycles(2);
        check("pending", 16'h1, 16'(conversion_pending_n));
        check("cleared", 16'h0, 16'(result_upper_lines.data));
        standalone = alone;
        start_pulse = 1'b0;
        for (n = 0; n < 50 && conversion_pending_n !== 1'b0; n++)
            cycles(1);
        if (n == 50)
        begin
            check("conversion end", 16'h0, 16'h1);
            end_sim();
        end
        if (alone)
        begin
            for (n = 0; n < 60 && result_upper_lines.oe !== 1'b1; n++)
                cycles(1);
            check("settle", 16'd25, 16'(n));
            check("alone word", 16'(code), 16'(host_word));
            return;
        end
        lower_bits_enable_n = 1'b0;
        cycles(2);
        check("upper off", 16'h0, 16'(result_upper_lines.oe));
        check("low byte", 16'({code[1:0], 6'h00}), 16'(low_byte));
        upper_byte_enable_n = 1'b0;
        cycles(2);
        check("word", 16'(code), 16'(host_word));
        upper_byte_enable_n = 1'b1;
        lower_bits_enable_n = 1'b1;
        cycles(2);
        check("released", 16'h0, 16'({result_upper_lines.oe,
            result_lower_lines.oe}));
    endtask
    initial
    begin
        cycles(16);
        check("reset pins", 16'h0, 16'({conversion_pending_n,
            result_upper_lines.oe, result_lower_lines.oe}));
        nrst = 1'b1;
        cycles(1);
        fill_fifo();
        // Codes run from 0 to 3FF in order; every fourth is stand-alone
        for (int i = 0; i < 32; i++)
            convert(10'(i * 33), 1'(i % 4 == 3));
        check("drained", 16'h1, 16'(core_ready));
        end_sim();
    end
endmodule
